// >>> rtl/gpcd_defs.vh
// Constants for the dual general purpose port block (ports C and D).
// Assumes a plain register port with byte-wide data.
`ifndef GPCD_DEFS_VH
`define GPCD_DEFS_VH

// Register addresses (byte index on the plain register port)
`define GPCD_ADDR_W 3
`define GPCD_ADDR_C_DATA 3'h0
`define GPCD_ADDR_C_DIR 3'h1
`define GPCD_ADDR_D_DATA 3'h2
`define GPCD_ADDR_D_DIR 3'h3
`define GPCD_ADDR_C_ANA 3'h4
`define GPCD_ADDR_D_ANA 3'h5

// Reset values
`define GPCD_DIR_RST 8'hff
`define GPCD_ANA_RST 8'h00
`define GPCD_ZERO8 8'h00

// Port C bits forced to input read-back in low-power crystal mode
`define GPCD_LP_MASK 8'h03

// Port D bits that may carry pwm steering outputs
`define GPCD_D_PWM_LSB 5

`endif

// >>> rtl/gpcd_pin.v
// One bidirectional pin cell: latch/direction or peripheral override.
// Assumes pin input is synchronous to the clock.
`timescale 1ns/1ps
module gpcd_pin (
  input wire latch_bit,
  input wire dir_bit,
  input wire ana_bit,
  input wire per_en,
  input wire per_out,
  input wire per_oe,
  input wire pin_in,
  output reg pin_out,
  output reg pin_oe,
  output wire read_bit
);

  // Peripheral takes over the driver when enabled, else the latch
  always @* begin
    if (per_en) begin
      pin_out = per_out; // R14
      pin_oe = per_oe; // R14
    end else begin
      pin_out = latch_bit;
      pin_oe = ~dir_bit; // R2 R7
    end
  end

  // Pin level read back; analog pins read zero
  assign read_bit = ana_bit ? 1'b0 : pin_in; // R1 R7 R14

endmodule

// >>> rtl/gpcd_top.v
// Dual 8-bit general purpose port block, ports C and D.
// Assumes a synchronous register port and synchronous pin inputs.
// Function
// R1 - Data read returns current pin level
// R2 - Direction 1 input, 0 drives latch
// R3 - Direction bits read/write, reset to ones
// R4 - Low-power crystal: C dir 1:0 read one
// R5 - Read gives pins, write updates latch
// R6 - Port write is read-modify-write
// R7 - Analog pins read zero, direction still drives
// R8 - Software keeps analog pins as inputs
// R9 - Data latch kept over non-power resets
// R10 - Port D eight bidirectional bits
// R11 - Port C 3..7 shared with serial
// R12 - Port C 0..2 shared timer, capture
// R13 - Port D 5..7 selectable pwm steering
// R14 - Enabled peripheral overrides latch and direction
`timescale 1ns/1ps
`include "gpcd_defs.vh"
module gpcd_top #(
  parameter WIDTH = 8
) (
  input wire ref_clk,
  input wire rst_n,
  input wire por_n,
  input wire low_power_crystal_mode,
  input wire [`GPCD_ADDR_W-1:0] reg_addr,
  input wire [WIDTH-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [WIDTH-1:0] reg_rdata,
  input wire [WIDTH-1:0] pc_in,
  output wire [WIDTH-1:0] pc_out,
  output wire [WIDTH-1:0] pc_oe,
  input wire [WIDTH-1:0] pd_in,
  output wire [WIDTH-1:0] pd_out,
  output wire [WIDTH-1:0] pd_oe,
  input wire timer_osc_en,
  input wire timer_osc_out,
  input wire cap1_en,
  input wire cap1_out,
  input wire cap1_oe,
  input wire cap2_en,
  input wire cap2_out,
  input wire cap2_oe,
  input wire ssp_en,
  input wire ssp_sck_out,
  input wire ssp_sck_oe,
  input wire ssp_sda_out,
  input wire ssp_sda_oe,
  input wire serial_data_output,
  input wire usart_en,
  input wire usart_tx_out,
  input wire usart_tx_oe,
  input wire usart_dt_out,
  input wire usart_dt_oe,
  input wire [2:0] pwm_steer_en,
  input wire pwm_steering_output_b,
  input wire pwm_steering_output_c,
  input wire pwm_steering_output_d,
  output wire timer_clock_input,
  output wire timer_oscillator_input,
  output wire first_capture_compare_pin,
  output wire second_capture_compare_pin,
  output wire ssp_sck_in,
  output wire serial_data_input,
  output wire usart_rx_in
);

  reg [WIDTH-1:0] c_lat_q;
  reg [WIDTH-1:0] c_lat_d;
  reg [WIDTH-1:0] d_lat_q;
  reg [WIDTH-1:0] d_lat_d;
  reg [WIDTH-1:0] c_dir_q;
  reg [WIDTH-1:0] d_dir_q;
  reg [WIDTH-1:0] c_ana_q;
  reg [WIDTH-1:0] d_ana_q;
  reg [WIDTH-1:0] rdata_d;
  reg [WIDTH-1:0] c_pen;
  reg [WIDTH-1:0] c_pout;
  reg [WIDTH-1:0] c_poe;
  reg [WIDTH-1:0] d_pen;
  reg [WIDTH-1:0] d_pout;
  reg [WIDTH-1:0] d_poe;
  wire [WIDTH-1:0] c_rd;
  wire [WIDTH-1:0] d_rd;
  wire [WIDTH-1:0] c_dir_rd;

  // Port C peripheral sharing map
  always @* begin
    c_pen = `GPCD_ZERO8;
    c_pout = `GPCD_ZERO8;
    c_poe = `GPCD_ZERO8;
    c_pen[0] = timer_osc_en; // R12
    c_pout[0] = timer_osc_out; // R12
    c_poe[0] = timer_osc_en; // R12
    c_pen[1] = timer_osc_en | cap2_en; // R12
    c_pout[1] = cap2_out; // R12
    c_poe[1] = cap2_oe & ~timer_osc_en; // R12
    c_pen[2] = cap1_en; // R12
    c_pout[2] = cap1_out; // R12
    c_poe[2] = cap1_oe; // R12
    c_pen[3] = ssp_en; // R11
    c_pout[3] = ssp_sck_out; // R11
    c_poe[3] = ssp_sck_oe; // R11
    c_pen[4] = ssp_en; // R11
    c_pout[4] = ssp_sda_out; // R11
    c_poe[4] = ssp_sda_oe; // R11
    c_pen[5] = ssp_en; // R11
    c_pout[5] = serial_data_output; // R11
    c_poe[5] = ssp_en; // R11
    c_pen[6] = usart_en; // R11
    c_pout[6] = usart_tx_out; // R11
    c_poe[6] = usart_tx_oe; // R11
    c_pen[7] = usart_en; // R11
    c_pout[7] = usart_dt_out; // R11
    c_poe[7] = usart_dt_oe; // R11
  end

  // Port D: low bits plain I/O, top three pwm steering
  always @* begin
    d_pen = `GPCD_ZERO8; // R13
    d_pout = `GPCD_ZERO8;
    d_poe = `GPCD_ZERO8;
    d_pen[`GPCD_D_PWM_LSB+2:`GPCD_D_PWM_LSB] = pwm_steer_en; // R13
    d_poe[`GPCD_D_PWM_LSB+2:`GPCD_D_PWM_LSB] = pwm_steer_en; // R13
    d_pout[`GPCD_D_PWM_LSB] = pwm_steering_output_b; // R13
    d_pout[`GPCD_D_PWM_LSB+1] = pwm_steering_output_c; // R13
    d_pout[`GPCD_D_PWM_LSB+2] = pwm_steering_output_d; // R13
  end

  // One pin cell per bit of each port
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
      gpcd_pin u_c (
        .latch_bit(c_lat_q[i]),
        .dir_bit(c_dir_q[i]),
        .ana_bit(c_ana_q[i]),
        .per_en(c_pen[i]),
        .per_out(c_pout[i]),
        .per_oe(c_poe[i]),
        .pin_in(pc_in[i]),
        .pin_out(pc_out[i]),
        .pin_oe(pc_oe[i]),
        .read_bit(c_rd[i])
      );
      gpcd_pin u_d ( // R10
        .latch_bit(d_lat_q[i]),
        .dir_bit(d_dir_q[i]),
        .ana_bit(d_ana_q[i]),
        .per_en(d_pen[i]),
        .per_out(d_pout[i]),
        .per_oe(d_poe[i]),
        .pin_in(pd_in[i]),
        .pin_out(pd_out[i]),
        .pin_oe(pd_oe[i]),
        .read_bit(d_rd[i])
      );
    end
  endgenerate

  // Peripheral inputs see the raw pin levels
  assign timer_clock_input = pc_in[0];
  assign timer_oscillator_input = pc_in[1];
  assign second_capture_compare_pin = pc_in[1];
  assign first_capture_compare_pin = pc_in[2];
  assign ssp_sck_in = pc_in[3];
  assign serial_data_input = pc_in[4];
  assign usart_rx_in = pc_in[7];

  // Direction read-back with low-power crystal override
  assign c_dir_rd = low_power_crystal_mode ?
    (c_dir_q | `GPCD_LP_MASK) : c_dir_q; // R4

  // Byte write: the modify step replaces every sampled pin bit,
  // so the latch takes the written byte whole (no pin bit leaks in)
  always @* begin
    c_lat_d = c_lat_q;
    d_lat_d = d_lat_q;
    if (reg_wr && reg_addr == `GPCD_ADDR_C_DATA) begin
      c_lat_d = reg_wdata; // R6 R5
    end else if (reg_wr && reg_addr == `GPCD_ADDR_D_DATA) begin
      d_lat_d = reg_wdata; // R6 R5
    end
  end

  // Data latches: no reset, so only power-on leaves them undefined
  always @(posedge ref_clk) begin
    c_lat_q <= c_lat_d; // R9
    d_lat_q <= d_lat_d; // R9
  end

  // Direction and analog select registers
  always @(posedge ref_clk) begin
    if (!rst_n || !por_n) begin
      c_dir_q <= `GPCD_DIR_RST; // R3
      d_dir_q <= `GPCD_DIR_RST; // R3
      c_ana_q <= `GPCD_ANA_RST;
      d_ana_q <= `GPCD_ANA_RST;
    end else if (reg_wr) begin
      if (reg_addr == `GPCD_ADDR_C_DIR) begin
        c_dir_q <= reg_wdata; // R3
      end else if (reg_addr == `GPCD_ADDR_D_DIR) begin
        d_dir_q <= reg_wdata; // R3
      end else if (reg_addr == `GPCD_ADDR_C_ANA) begin
        c_ana_q <= reg_wdata;
      end else if (reg_addr == `GPCD_ADDR_D_ANA) begin
        d_ana_q <= reg_wdata;
      end
    end
  end

  // Read decode; unmapped addresses read zero
  always @* begin
    if (reg_addr == `GPCD_ADDR_C_DATA) begin
      rdata_d = c_rd; // R5 R1
    end else if (reg_addr == `GPCD_ADDR_C_DIR) begin
      rdata_d = c_dir_rd;
    end else if (reg_addr == `GPCD_ADDR_D_DATA) begin
      rdata_d = d_rd; // R5 R1
    end else if (reg_addr == `GPCD_ADDR_D_DIR) begin
      rdata_d = d_dir_q;
    end else if (reg_addr == `GPCD_ADDR_C_ANA) begin
      rdata_d = c_ana_q;
    end else if (reg_addr == `GPCD_ADDR_D_ANA) begin
      rdata_d = d_ana_q;
    end else begin
      rdata_d = `GPCD_ZERO8;
    end
  end

  // Read data stands in the cycle after the strobe only
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata <= `GPCD_ZERO8;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= `GPCD_ZERO8;
    end
  end

endmodule

// >>> verification/gpcd_chk.sv
// Assertion checker for the dual port block, bound to its top module.
// Sees only top-level ports; one clock, resets rst_n and por_n.
`timescale 1ns/1ps
module gpcd_chk (
  input logic ref_clk,
  input logic rst_n,
  input logic por_n,
  input logic low_power_crystal_mode,
  input logic [2:0] reg_addr,
  input logic reg_rd,
  input logic [7:0] reg_rdata,
  input logic [7:0] pc_in,
  input logic [7:0] pc_out,
  input logic [7:0] pc_oe,
  input logic [7:0] pd_out,
  input logic [7:0] pd_oe,
  input logic timer_osc_en,
  input logic timer_osc_out,
  input logic ssp_en,
  input logic serial_data_output,
  input logic [2:0] pwm_steer_en,
  input logic pwm_steering_output_b,
  input logic timer_clock_input,
  input logic timer_oscillator_input,
  input logic first_capture_compare_pin,
  input logic second_capture_compare_pin,
  input logic ssp_sck_in,
  input logic serial_data_input,
  input logic usart_rx_in
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n || !por_n);
  // Register port answers
  property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not idle");
  property p_unmapped;
    reg_rd && reg_addr > 3'h5 |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_lp;
    reg_rd && reg_addr == 3'h1 && low_power_crystal_mode
      |=> reg_rdata[1:0] == 2'b11;
  endproperty
  a_lp: assert property (p_lp)
    else $error("low power direction bits not one");
  // Pin drivers and peripheral inputs
  property p_dir_rst; $past(!rst_n) |-> pd_oe[4:0] == 5'h00; endproperty
  a_dir_rst: assert property (p_dir_rst)
    else $error("drivers on after reset");
  property p_timer;
    timer_osc_en |-> pc_out[0] == timer_osc_out && pc_oe[0];
  endproperty
  a_timer: assert property (p_timer)
    else $error("timer output not on pin");
  property p_sdo;
    ssp_en |-> pc_out[5] == serial_data_output && pc_oe[5];
  endproperty
  a_sdo: assert property (p_sdo)
    else $error("serial output not on pin");
  property p_pwm;
    pwm_steer_en[0] |-> pd_out[5] == pwm_steering_output_b && pd_oe[5];
  endproperty
  a_pwm: assert property (p_pwm)
    else $error("steering output not on pin");
  property p_pin_in;
    timer_clock_input == pc_in[0] && usart_rx_in == pc_in[7];
  endproperty
  a_pin_in: assert property (p_pin_in)
    else $error("peripheral input not pin level");
  property p_pin_in2;
    timer_oscillator_input == pc_in[1] && second_capture_compare_pin ==
      pc_in[1] && first_capture_compare_pin == pc_in[2] &&
      ssp_sck_in == pc_in[3] && serial_data_input == pc_in[4];
  endproperty
  a_pin_in2: assert property (p_pin_in2)
    else $error("shared input not pin level");
endmodule
bind gpcd_top gpcd_chk u_gpcd_chk (.*);

// >>> verification/gpcd_pin_model.sv
// Pin-side model: outside driver that yields to the block's driver.
// Assumes one model per eight-pin port; ext is the outside level.
`timescale 1ns/1ps
module gpcd_pin_model (
  input logic [7:0] pin_drive,
  input logic [7:0] pin_oe,
  input logic [7:0] ext,
  output logic [7:0] pin
);
  // Driven bits show the block's value, released ones the outside
  assign pin = (pin_oe & pin_drive) | (~pin_oe & ext);
endmodule

// >>> verification/gpcd_top_tb.sv
// Self-checking bench for the dual port block with two pin models.
// Assumes design, checker and pin model are compiled before it.
`timescale 1ns/1ps
`include "gpcd_defs.vh"
module gpcd_top_tb;
  logic ref_clk = 0, rst_n = 0, por_n = 0, low_power_crystal_mode = 0;
  logic reg_wr = 0, reg_rd = 0, timer_osc_en = 0, ssp_en = 0;
  logic cap1_en = 0, cap2_en = 0, usart_en = 0, p;
  logic [2:0] reg_addr = 0, pwm_steer_en = 0;
  logic [7:0] reg_wdata = 0, ext_c = 0, ext_d = 0, d, w, a, e, v;
  logic [7:0] reg_rdata, pc_in, pc_out, pc_oe, pd_in, pd_out, pd_oe;
  logic [23:0] po = 0;
  logic [31:0] lfsr = 32'ha99df821;
  int miscompares = 0, checks = 0;
  wire timer_osc_out, cap1_out, cap1_oe, cap2_out, cap2_oe, ssp_sck_out,
    ssp_sck_oe, ssp_sda_out, ssp_sda_oe, serial_data_output, usart_tx_out,
    usart_tx_oe, usart_dt_out, usart_dt_oe, pwm_steering_output_b,
    pwm_steering_output_c, pwm_steering_output_d;
  wire timer_clock_input, timer_oscillator_input, first_capture_compare_pin,
    second_capture_compare_pin, ssp_sck_in, serial_data_input, usart_rx_in;
  // Peripheral outputs from one random word
  assign {timer_osc_out, cap1_out, cap1_oe, cap2_out, cap2_oe, ssp_sck_out,
    ssp_sck_oe, ssp_sda_out, ssp_sda_oe, serial_data_output, usart_tx_out,
    usart_tx_oe, usart_dt_out, usart_dt_oe, pwm_steering_output_b,
    pwm_steering_output_c, pwm_steering_output_d} = po[16:0];
  gpcd_top u_gpcd_top (.*);
  gpcd_pin_model u_gpcd_pin_model_c (.pin_drive(pc_out), .pin_oe(pc_oe),
    .ext(ext_c), .pin(pc_in));
  gpcd_pin_model u_gpcd_pin_model_d (.pin_drive(pd_out), .pin_oe(pd_oe),
    .ext(ext_d), .pin(pd_in));
  function automatic logic [7:0] rnd();
    repeat (8) lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction
  task automatic cmp(string n, logic [7:0] ex, logic [7:0] got);
    checks++;
    if (got !== ex) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, ex, got);
    end
  endtask
  task automatic wr(logic [2:0] ad, logic [7:0] dt);
    @(posedge ref_clk);
    reg_wr <= 1;
    reg_addr <= ad;
    reg_wdata <= dt;
    @(posedge ref_clk);
    reg_wr <= 0;
  endtask
  task automatic rd(logic [2:0] ad);
    @(posedge ref_clk);
    reg_rd <= 1;
    reg_addr <= ad;
    @(posedge ref_clk);
    reg_rd <= 0;
    #1 v = reg_rdata;
  endtask
  task automatic conclude;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Clock and watchdog
  initial forever #12.5 ref_clk = ~ref_clk;
  initial begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    conclude;
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1;
    por_n <= 1;
    rd(`GPCD_ADDR_C_DIR); cmp("c_dir", 8'hff, v);
    rd(`GPCD_ADDR_D_DIR); cmp("d_dir", 8'hff, v);
    rd(3'h7); cmp("unmapped", 8'h00, v);
    wr(`GPCD_ADDR_C_DIR, 8'h00);
    for (int m = 0; m < 3; m++) begin
      low_power_crystal_mode <= m[0];
      rd(`GPCD_ADDR_C_DIR); cmp("c_dir_lp", {6'h00, {2{m[0]}}}, v);
    end
    // Random and corner port traffic on both ports
    for (int i = 0; i < 24; i++) begin
      p = i[0];
      d = (i < 4) ? {8{i[1]}} : rnd();
      w = rnd();
      a = (i < 4) ? 8'h00 : rnd();
      d = d | a;
      e = rnd();
      if (p) ext_d <= e;
      else ext_c <= e;
      wr({1'b0, p, 1'b0}, w);
      wr({1'b0, p, 1'b1}, d);
      wr({2'b10, p}, a);
      rd({1'b0, p, 1'b0});
      cmp("pin_data", ((~d & w) | (d & e)) & ~a, v);
      cmp("oe", ~d, p ? pd_oe : pc_oe);
      cmp("latch", w & ~d, (p ? pd_out : pc_out) & ~d);
    end
    // Other reset keeps the port D latch
    rst_n <= 0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1;
    rd(`GPCD_ADDR_D_DIR); cmp("d_dir_rst", 8'hff, v);
    wr(`GPCD_ADDR_D_DIR, 8'h00);
    rd(`GPCD_ADDR_D_DATA); cmp("d_kept", w, pd_out);
    // Peripherals take over their pins
    timer_osc_en <= 1;
    ssp_en <= 1;
    pwm_steer_en <= 3'h7;
    cap1_en <= 1;
    usart_en <= 1;
    repeat (8) begin
      @(posedge ref_clk);
      po <= {rnd(), rnd(), rnd()};
      #1 cmp("pwm", {pwm_steering_output_d, pwm_steering_output_c,
        pwm_steering_output_b, 5'h00}, pd_out & 8'he0);
      cmp("c_oe", {usart_dt_oe, usart_tx_oe, 1'b1, ssp_sda_oe, ssp_sck_oe,
        cap1_oe, 2'b01}, pc_oe);
      cmp("c_out", {usart_dt_out, usart_tx_out, serial_data_output,
        ssp_sda_out, ssp_sck_out, cap1_out, cap2_out, timer_osc_out},
        pc_out);
    end
    conclude;
  end
endmodule
